// ==== design/adcs_host.sv ====
// What this block does
// - Successive rising edges of the sample trigger are at least 1.25 us apart.
// - The sample trigger stays high and low for at least 10 ns each pulse.
// - Reads after a conversion start no earlier than the busy falling edge.
// - Reads during a conversion end at least 25 ns before busy falls.
// - A reset pulse of 55 to 2000 ns is partial and one of 3000 ns or more is full.
// - The first trigger waits 50 ns after a partial and 253 us after a full reset.
// - Conversions wait 1 us after standby and 10 ms after shutdown.
// - The initialising reset comes at least 10 ms after the supplies are stable.
`timescale 1ns/100ps
module adcs_host
#(
  parameter int unsigned PWRUP_CYC      = adcs_pkg::CYC_POWER_UP,
  parameter int unsigned FULL_SETUP_CYC = adcs_pkg::CYC_FULL_SETUP,
  parameter int unsigned SHDN_WAKE_CYC  = adcs_pkg::CYC_WAKE_SHDN
)
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // User requests
  input  wire logic convStart,
  input  wire logic resetStart,
  input  wire logic resetFull,
  input  wire logic wakeStart,
  input  wire logic wakeFromShutdown,
  // User status
  output logic      ready,
  output logic      startAck,
  output logic      convDone,
  output logic      convError,
  output logic      readAllowed,
  output logic      readDuringOk,
  // Converter pins
  output logic      sampleTrigger,
  output logic      adcReset,
  input  wire logic busyPin
);

  localparam int unsigned TW = adcs_pkg::TIMER_W;
  localparam int unsigned CW = adcs_pkg::CNT_W;
  localparam int unsigned SW = adcs_pkg::SPACE_W;

  adcs_pkg::adcs_state_t state;
  logic [TW-1:0]         timer;
  logic [CW-1:0]         convCnt;
  logic [SW-1:0]         spaceCnt;
  logic                  sawBusy;
  logic                  lastFull;
  logic                  busySync;

  adcs_sync u_busy_sync
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (busyPin),
    .dout  (busySync)
  );

  assign ready    = (state == adcs_pkg::ST_IDLE) && (spaceCnt == SW'(0));
  assign startAck = ready && convStart && !resetStart && !wakeStart;

  assign readDuringOk = (state == adcs_pkg::ST_CONV) &&
                        (convCnt < CW'(adcs_pkg::CYC_READ_DURING));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      spaceCnt <= adcs_pkg::SPACE_RST;
    else if (startAck)
      spaceCnt <= SW'(adcs_pkg::CYC_CYCLE - 1);
    else if (spaceCnt != SW'(0))
      spaceCnt <= spaceCnt - SW'(1);
  end

  // Sequencer; the power-up wait runs from reset release of this block
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state         <= adcs_pkg::ST_PWRUP;
      timer         <= TW'(PWRUP_CYC - 1);
      sampleTrigger <= 1'b0;
      adcReset      <= 1'b0;
      lastFull      <= 1'b1;
      sawBusy       <= 1'b0;
      convCnt       <= adcs_pkg::CNT_RST;
      convDone      <= 1'b0;
      convError     <= 1'b0;
    end
    else
    begin
      convDone  <= 1'b0;
      convError <= 1'b0;
      case (state)
        adcs_pkg::ST_PWRUP:
          if (timer == TW'(0))
          begin
            state    <= adcs_pkg::ST_RESET;
            adcReset <= 1'b1;
            lastFull <= 1'b1;
            timer    <= TW'(adcs_pkg::CYC_FULL_RST - 1);
          end
          else
            timer <= timer - TW'(1);
        adcs_pkg::ST_RESET:
          if (timer == TW'(0))
          begin
            state    <= adcs_pkg::ST_SETUP;
            adcReset <= 1'b0;
            timer    <= lastFull ? TW'(FULL_SETUP_CYC - 1)
                                 : TW'(adcs_pkg::CYC_PART_SETUP - 1);
          end
          else
            timer <= timer - TW'(1);
        adcs_pkg::ST_SETUP:
          if (timer == TW'(0))
            state <= adcs_pkg::ST_IDLE;
          else
            timer <= timer - TW'(1);
        adcs_pkg::ST_IDLE:
          if (resetStart)
          begin
            state    <= adcs_pkg::ST_RESET;
            adcReset <= 1'b1;
            lastFull <= resetFull;
            timer    <= resetFull ? TW'(adcs_pkg::CYC_FULL_RST - 1)
                                  : TW'(adcs_pkg::CYC_PART_RST - 1);
          end
          else if (wakeStart)
          begin
            state <= adcs_pkg::ST_WAKE;
            timer <= wakeFromShutdown ? TW'(SHDN_WAKE_CYC - 1)
                                      : TW'(adcs_pkg::CYC_WAKE_STBY - 1);
          end
          else if (startAck)
          begin
            state         <= adcs_pkg::ST_TRIGHI;
            sampleTrigger <= 1'b1;
            timer         <= TW'(adcs_pkg::CYC_TRIG_HIGH - 1);
          end
        adcs_pkg::ST_TRIGHI:
          if (timer == TW'(0))
          begin
            state         <= adcs_pkg::ST_CONV;
            sampleTrigger <= 1'b0;
            sawBusy       <= 1'b0;
            convCnt       <= CW'(adcs_pkg::CYC_TRIG_HIGH);
          end
          else
            timer <= timer - TW'(1);
        adcs_pkg::ST_CONV:
        begin
          convCnt <= convCnt + CW'(1);
          // busy must show up, allowing for the synchroniser
          if (!sawBusy && busySync)
            sawBusy <= 1'b1;
          else if (!sawBusy &&
                   convCnt >= CW'(adcs_pkg::CYC_BUSY_RISE + adcs_pkg::SYNC_LAT))
          begin
            state     <= adcs_pkg::ST_IDLE;
            convError <= 1'b1;
          end
          else if (sawBusy && !busySync)
          begin
            state    <= adcs_pkg::ST_IDLE;
            convDone <= 1'b1;
          end
          // busy stuck beyond the longest conversion
          else if (convCnt >= CW'(adcs_pkg::CYC_CONV_MAX + adcs_pkg::SYNC_LAT))
          begin
            state     <= adcs_pkg::ST_IDLE;
            convError <= 1'b1;
          end
        end
        adcs_pkg::ST_WAKE:
          if (timer == TW'(0))
            state <= adcs_pkg::ST_IDLE;
          else
            timer <= timer - TW'(1);
        default:
        begin
          state         <= adcs_pkg::ST_IDLE;
          sampleTrigger <= 1'b0;
          adcReset      <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      readAllowed <= 1'b0;
    else if (startAck || (state == adcs_pkg::ST_RESET))
      readAllowed <= 1'b0;
    else if (state == adcs_pkg::ST_CONV && sawBusy && !busySync)
      readAllowed <= 1'b1;
  end

  // Helper counters for the checks below
  logic [TW-1:0] sinceRise;
  logic [TW-1:0] rstLen;
  logic [TW-1:0] sinceRstFall;
  logic [TW-1:0] sinceWake;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sinceRise    <= '1;
      rstLen       <= '0;
      sinceRstFall <= '0;
      sinceWake    <= '1;
    end
    else
    begin
      sinceRise    <= startAck ? TW'(0) : (&sinceRise ? sinceRise : sinceRise + TW'(1));
      rstLen       <= adcReset ? rstLen + TW'(1) : TW'(0);
      sinceRstFall <= adcReset ? TW'(0) :
                      (&sinceRstFall ? sinceRstFall : sinceRstFall + TW'(1));
      sinceWake    <= (state == adcs_pkg::ST_WAKE) ? TW'(0) :
                      (&sinceWake ? sinceWake : sinceWake + TW'(1));
    end
  end

  a_trig_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(sampleTrigger) |-> $past(sinceRise) >= TW'(adcs_pkg::CYC_CYCLE - 1))
    else $error("Trigger edges closer than the minimum cycle");

  a_trig_widths: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(sampleTrigger) |=> !sampleTrigger [*8])
    else $error("Trigger high or low width wrong");

  a_busy_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == adcs_pkg::ST_CONV && !sawBusy && !busySync &&
     convCnt >= CW'(adcs_pkg::CYC_BUSY_RISE + adcs_pkg::SYNC_LAT))
    |=> state == adcs_pkg::ST_IDLE && convError)
    else $error("Missing busy not flagged in time");

  a_conv_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    state == adcs_pkg::ST_CONV |-> convCnt <= CW'(adcs_pkg::CYC_CONV_MAX + adcs_pkg::SYNC_LAT))
    else $error("Conversion watch ran past its limit");

  a_read_after: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(readAllowed) |-> convDone && !busySync && !sampleTrigger)
    else $error("Read allowed while busy");

  a_read_during: assert property (@(posedge mclk) disable iff (!rst_n)
    readDuringOk |-> convCnt < CW'(adcs_pkg::CYC_READ_DURING) && !readAllowed)
    else $error("Read window overlaps end of conversion");

  a_rst_length: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(adcReset) |-> (lastFull ? rstLen >= TW'(adcs_pkg::CYC_FULL_RST)
                        : (rstLen >= TW'(adcs_pkg::CYC_PART_RST) &&
                           rstLen <= TW'(adcs_pkg::CYC_PART_RST_MAX))))
    else $error("Reset pulse length outside its class");

  a_setup_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(sampleTrigger) |-> $past(sinceRstFall) >=
      (lastFull ? TW'(FULL_SETUP_CYC) : TW'(adcs_pkg::CYC_PART_SETUP)))
    else $error("Trigger too soon after reset");

  a_wake_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    state == adcs_pkg::ST_WAKE |-> !sampleTrigger && !startAck)
    else $error("Trigger during wake-up wait");

  a_power_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    state == adcs_pkg::ST_PWRUP |-> !adcReset && !sampleTrigger)
    else $error("Converter touched before power-up wait");

  a_conv_done: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == adcs_pkg::ST_CONV && sawBusy && !busySync) |=> convDone && readAllowed)
    else $error("Busy fall did not complete the conversion");

  c_conv_done:  cover property (@(posedge mclk) disable iff (!rst_n) convDone);
  c_conv_error: cover property (@(posedge mclk) disable iff (!rst_n) convError);
  c_part_reset: cover property (@(posedge mclk) disable iff (!rst_n) $fell(adcReset) && !lastFull);
  c_wake_done:  cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(state == adcs_pkg::ST_WAKE));

endmodule // adcs_host

// ==== design/adcs_pkg.sv ====
package adcs_pkg;

  // Clock
  localparam int unsigned CLK_NS = 10;

  // Times as printed, in ns
  localparam int unsigned T_CYCLE_NS       = 1250;
  localparam int unsigned T_TRIG_HIGH_NS   = 10;
  localparam int unsigned T_TRIG_LOW_NS    = 10;
  localparam int unsigned T_BUSY_RISE_NS   = 25;
  localparam int unsigned T_CONV_MIN_NS    = 650;
  localparam int unsigned T_CONV_MAX_NS    = 850;
  localparam int unsigned T_READ_GUARD_NS  = 25;
  localparam int unsigned T_PART_RST_NS    = 55;
  localparam int unsigned T_PART_RST_MAX_NS = 2000;
  localparam int unsigned T_FULL_RST_NS    = 3000;
  localparam int unsigned T_PART_SETUP_NS  = 50;
  localparam int unsigned T_FULL_SETUP_NS  = 253000;
  localparam int unsigned T_WAKE_STBY_NS   = 1000;
  localparam int unsigned T_WAKE_SHDN_NS   = 10000000;
  localparam int unsigned T_POWER_UP_NS    = 10000000;

  // Least times round up, longest round down
  localparam int unsigned CYC_CYCLE       = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_TRIG_HIGH   = (T_TRIG_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_TRIG_LOW    = (T_TRIG_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_BUSY_RISE   = T_BUSY_RISE_NS / CLK_NS;
  localparam int unsigned CYC_CONV_MAX    = T_CONV_MAX_NS / CLK_NS;
  localparam int unsigned CYC_READ_DURING = (T_CONV_MIN_NS - T_READ_GUARD_NS) / CLK_NS;
  localparam int unsigned CYC_PART_RST    = (T_PART_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_PART_RST_MAX = T_PART_RST_MAX_NS / CLK_NS;
  localparam int unsigned CYC_FULL_RST    = (T_FULL_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_PART_SETUP  = (T_PART_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_FULL_SETUP  = (T_FULL_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_WAKE_STBY   = (T_WAKE_STBY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_WAKE_SHDN   = (T_WAKE_SHDN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CYC_POWER_UP    = (T_POWER_UP_NS + CLK_NS - 1) / CLK_NS;

  // Latency of the busy input synchroniser: three stages and the output register, no slack
  localparam int unsigned SYNC_LAT = 4;

  // Counter widths and reset values
  localparam int unsigned TIMER_W = 24;
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned SPACE_W = 8;
  localparam logic [CNT_W-1:0]   CNT_RST   = 8'h00;
  localparam logic [SPACE_W-1:0] SPACE_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_PWRUP  = 3'b000,
    ST_RESET  = 3'b001,
    ST_SETUP  = 3'b011,
    ST_IDLE   = 3'b010,
    ST_TRIGHI = 3'b110,
    ST_CONV   = 3'b111,
    ST_WAKE   = 3'b101
  } adcs_state_t;

endpackage

// ==== design/adcs_sync.sv ====
`timescale 1ns/100ps
module adcs_sync
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Asynchronous input and filtered level
  input  wire logic din,
  output logic      dout
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Level changes only once the second and third stages agree
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        dout <= stage3;
    end
  end

endmodule // adcs_sync

// ==== tb/adcs_dev_model.sv ====
`timescale 1ns/100ps
module adcs_dev_model
#(
  parameter realtime FULL_SETUP_NS = 253000.0
)
(
  // Converter pins
  input  wire logic sampleTrigger,
  input  wire logic adcReset,
  output logic      busyPin,
  // Speed and fault control
  input  wire logic slowConv,
  input  wire logic stuckBusy,
  input  wire logic deadBusy
);
  realtime lastTrig = -1.0e9;
  realtime rstRise  = -1.0;
  realtime rstFall  = -1.0e9;
  realtime setupNs  = 50.0;
  int      viol     = 0;
  int      rstKind  = 0;

  initial busyPin = 1'b0;

  always @(posedge sampleTrigger)
  begin
    if ($realtime - lastTrig < 1250.0 || $realtime - rstFall < setupNs || adcReset)
      viol++;
    lastTrig = $realtime;
  end

  // busy within 20 ns, held over conversion
  always @(posedge sampleTrigger)
  begin
    if (!deadBusy)
    begin
      // Busy edges fall between clock edges so the synchroniser sees no race
      #15 busyPin = 1'b1;
      if (!stuckBusy)
        #((slowConv ? 845.0 : 655.0) - 15.0) busyPin = 1'b0;
    end
  end

  always @(posedge adcReset)
  begin
    rstRise = $realtime;
    busyPin = 1'b0;
  end

  // width decides partial or full reset
  always @(negedge adcReset)
  begin
    // The pin settling out of the host's own reset is no pulse
    if (rstRise >= 0.0)
    begin
      rstFall = $realtime;
      if (rstFall - rstRise >= 3000.0)
      begin
        rstKind = 2;
        setupNs = FULL_SETUP_NS;
      end
      else if (rstFall - rstRise >= 55.0 && rstFall - rstRise <= 2000.0)
      begin
        rstKind = 1;
        setupNs = 50.0;
      end
      else
      begin
        rstKind = 0;
        viol++;
      end
    end
  end
endmodule // adcs_dev_model

// ==== tb/adc_conversion_sequencer_bench.sv ====
`timescale 1ns/100ps
module adc_conversion_sequencer_bench;
  logic mclk             = 1'b0;
  logic rst_n            = 1'b0;
  logic convStart        = 1'b0;
  logic resetStart       = 1'b0;
  logic resetFull        = 1'b0;
  logic wakeStart        = 1'b0;
  logic wakeFromShutdown = 1'b0;
  logic slowConv         = 1'b0;
  logic stuckBusy        = 1'b0;
  logic deadBusy         = 1'b0;
  logic ready, startAck, convDone, convError, readAllowed, readDuringOk;
  logic sampleTrigger, adcReset, busyPin;
  int   errCount   = 0;
  int   nCompared  = 0;
  int   cyc        = 0;
  int   ackCyc     = 0;

  adcs_host #(.PWRUP_CYC(20), .FULL_SETUP_CYC(20), .SHDN_WAKE_CYC(20)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .convStart(convStart), .resetStart(resetStart),
    .resetFull(resetFull), .wakeStart(wakeStart), .wakeFromShutdown(wakeFromShutdown),
    .ready(ready), .startAck(startAck), .convDone(convDone), .convError(convError),
    .readAllowed(readAllowed), .readDuringOk(readDuringOk),
    .sampleTrigger(sampleTrigger), .adcReset(adcReset), .busyPin(busyPin));

  // Device setup shortened to match the shortened design count
  adcs_dev_model #(.FULL_SETUP_NS(200.0)) dev (
    .sampleTrigger(sampleTrigger), .adcReset(adcReset), .busyPin(busyPin),
    .slowConv(slowConv), .stuckBusy(stuckBusy), .deadBusy(deadBusy));

  always #5 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errCount++;
      $display("ERROR %0t run timed out", $time);
      wrapUp();
    end
  end

  task automatic wrapUp();
    $display("Compared %0d, errors %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic g, input logic e, input string m);
    nCompared++;
    if (g !== e)
    begin
      errCount++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic chkRange(input int v, input int lo, input int hi, input string m);
    nCompared++;
    if (v < lo || v > hi)
    begin
      errCount++;
      $display("ERROR %0t %s: %0d", $time, m, v);
    end
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic untilReady(output int k);
    for (k = 0; k < 200 && ready !== 1'b1; k++) tick();
  endtask

  task automatic pulseLen(output int w, output int len);
    for (w = 0; w < 400 && adcReset !== 1'b1; w++) tick();
    for (len = 0; len < 400 && adcReset === 1'b1; len++) tick();
  endtask

  task automatic startConv();
    int k;
    untilReady(k);
    convStart = 1'b1;
    #1;
    chk(startAck, 1'b1, "start not taken");
    ackCyc = cyc;
    tick();
    convStart = 1'b0;
    chk(sampleTrigger, 1'b1, "trigger not high");
  endtask

  task automatic t_power();
    int w, len, k;
    pulseLen(w, len);
    chkRange(w, 19, 22, "power-up wait");
    chkRange(len, 300, 300, "power-up reset width");
    untilReady(k);
    chkRange(k, 19, 25, "full setup wait");
  endtask

  // Reads of old data must end before busy can fall; new reads only after
  task automatic t_conv(input logic slow);
    int k, prev;
    logic sawOk;
    sawOk = 1'b0;
    slowConv = slow;
    prev = ackCyc;
    startConv();
    if (prev != 0)
      chkRange(ackCyc - prev, 125, 127, "trigger spacing");
    tick();
    chk(sampleTrigger, 1'b0, "trigger not one cycle");
    for (k = 0; k < 120 && convDone !== 1'b1; k++)
    begin
      sawOk = sawOk | (readDuringOk === 1'b1);
      tick();
    end
    chkRange(k, slow ? 84 : 64, slow ? 92 : 72, "conversion length");
    chk(busyPin, 1'b0, "done before busy fell");
    chk(readAllowed, 1'b1, "read not allowed");
    chk(readDuringOk, 1'b0, "late read window");
    chk(sawOk, 1'b1, "no read window");
  endtask

  task automatic t_fault();
    int k;
    deadBusy = 1'b1;
    startConv();
    for (k = 0; k < 40 && convError !== 1'b1; k++) tick();
    chkRange(k, 3, 12, "missing busy error");
    deadBusy = 1'b0;
    stuckBusy = 1'b1;
    startConv();
    for (k = 0; k < 120 && convError !== 1'b1; k++) tick();
    chkRange(k, 84, 92, "stuck busy error");
    stuckBusy = 1'b0;
  endtask

  task automatic t_reset();
    int w, len, k;
    for (int f = 0; f < 2; f++)
    begin
      untilReady(k);
      resetStart = 1'b1;
      resetFull = f[0];
      tick();
      resetStart = 1'b0;
      pulseLen(w, len);
      chkRange(len, f ? 300 : 6, f ? 300 : 6, "reset width");
      chkRange(dev.rstKind, f + 1, f + 1, "reset kind");
      untilReady(k);
      chkRange(k, f ? 19 : 4, f ? 25 : 9, "setup wait");
      startConv();
    end
  endtask

  task automatic t_wake();
    int k;
    for (int s = 0; s < 2; s++)
    begin
      untilReady(k);
      wakeStart = 1'b1;
      wakeFromShutdown = s[0];
      tick();
      wakeStart = 1'b0;
      chk(ready, 1'b0, "ready during wake");
      untilReady(k);
      chkRange(k, s ? 18 : 98, s ? 22 : 102, "wake wait");
    end
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_power();
    t_conv(1'b0);
    t_conv(1'b1);
    t_fault();
    t_reset();
    t_wake();
    chkRange(dev.viol, 0, 0, "device timing broken");
    wrapUp();
  end
endmodule // adc_conversion_sequencer_bench
